// ===== inc/rcpc_pkg.sv
// Package: constants, encodings and register map
package rcpc_pkg;

    // ==================================================================
    // Timing
    // ==================================================================
    localparam int unsigned CLK_PERIOD_NS  = 8;        // 125 MHz system clock
    localparam int unsigned DET_PERIOD_MS  = 6;        // Receiver detection repeat period
    localparam int unsigned NS_PER_MS      = 1000000;  // Unit conversion
    // Rounded down: a longest time between detections
    localparam int unsigned DET_PERIOD_CYC = (DET_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int unsigned PER_CNT_W      = 20;       // Holds DET_PERIOD_CYC
    localparam int unsigned IDLE_W         = 16;       // Idle qualification counter width

    // ==================================================================
    // Channel modes, one-hot
    // ==================================================================
    typedef enum logic [3:0] {
        RCPC_POWER_DOWN_MODE = 4'h1,  // Pair disabled
        RCPC_UNPLUG          = 4'h2,  // No far-end load
        RCPC_SLUMBER         = 4'h4,  // Low power, input idle
        RCPC_ACTIVE          = 4'h8   // Normal operation
    } rcpc_mode_e;

    // ==================================================================
    // Termination selections
    // ==================================================================
    localparam logic [1:0] RX_TERM_HIZ    = 2'h0;  // Input open
    localparam logic [1:0] RX_TERM_67K_GN = 2'h1;  // Weak pull to ground
    localparam logic [1:0] RX_TERM_50_VDD = 2'h2;  // 50 ohm to supply
    localparam logic [1:0] TX_TERM_HIZ    = 2'h0;  // Output open
    localparam logic [1:0] TX_TERM_40K_VD = 2'h1;  // Weak pull to supply
    localparam logic [1:0] TX_TERM_50_VDD = 2'h2;  // 50 ohm to supply

    // ==================================================================
    // Four-level pin decode
    // ==================================================================
    localparam logic [2:0] LVL_THERM_L = 3'h0;  // Comparator code, tied low
    localparam logic [2:0] LVL_THERM_R = 3'h1;  // Resistor to ground
    localparam logic [2:0] LVL_THERM_F = 3'h3;  // Left open
    localparam logic [2:0] LVL_THERM_H = 3'h7;  // Tied high
    localparam logic [1:0] SET_L       = 2'h0;  // Setting codes
    localparam logic [1:0] SET_R       = 2'h1;
    localparam logic [1:0] SET_F       = 2'h2;  // Default setting
    localparam logic [1:0] SET_H       = 2'h3;

    // ==================================================================
    // Register map (byte addresses)
    // ==================================================================
    localparam logic [7:0] REG_CTRL      = 8'h00;  // Software pair enables
    localparam logic [7:0] REG_IDLE_QUAL = 8'h04;  // Idle qualification cycles
    localparam logic [7:0] REG_STATUS    = 8'h08;  // Channel modes
    localparam logic [7:0] REG_SETTINGS  = 8'h0c;  // Decoded EQ and gain codes
    localparam int unsigned CTRL_AB_BIT  = 0;
    localparam int unsigned CTRL_CD_BIT  = 1;
    localparam logic [IDLE_W-1:0] IDLE_QUAL_RST = 16'h0400;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;

endpackage

// ===== rtl/rcpc_chan.sv
// Per-channel mode machine with detection timing
module rcpc_chan #(
    parameter logic [rcpc_pkg::PER_CNT_W-1:0] DET_PERIOD = 20'hb71b0  // 6 ms in cycles
) (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          clk_en,
    input  wire logic                          pair_en,     // Pair enable after pin and software
    input  wire logic                          sig_active,  // Signal detector sees activity
    input  wire logic                          det_done,    // Far-end detection finished
    input  wire logic                          det_load,    // Result: load present
    input  wire logic [rcpc_pkg::IDLE_W-1:0]   idle_qual,   // Idle cycles before slumber
    output rcpc_pkg::rcpc_mode_e               mode,
    output logic      [1:0]                    rx_term,
    output logic      [1:0]                    tx_term,
    output logic                               sd_enable,
    output logic                               det_req
);

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        rcpc_pkg::rcpc_mode_e                mode;     // Current mode
        logic [rcpc_pkg::IDLE_W-1:0]         idle;     // Idle cycles seen
        logic [rcpc_pkg::PER_CNT_W-1:0]      per;      // Cycles to next detection
        logic                                det;      // Detection request
        logic [1:0]                          rx;
        logic [1:0]                          tx;
        logic                                sd;
    } rcpc_chan_s;

    rcpc_chan_s st_r;
    rcpc_chan_s st_nxt;

    // Next state; each channel has its own copy, so idle never spreads
    always_comb begin
        st_nxt = st_r;
        if (!pair_en) begin
            st_nxt.mode = rcpc_pkg::RCPC_POWER_DOWN_MODE;  // RULE1
            st_nxt.det  = 1'b0;
        end else begin
            case (st_r.mode)
                rcpc_pkg::RCPC_POWER_DOWN_MODE: begin
                    st_nxt.mode = rcpc_pkg::RCPC_ACTIVE;  // RULE1
                    st_nxt.idle = '0;
                end
                rcpc_pkg::RCPC_ACTIVE: begin
                    // Qualify idle for a set time so short gaps do not drop the link
                    if (sig_active) begin
                        st_nxt.idle = '0;
                    end else if (st_r.idle >= idle_qual) begin
                        st_nxt.mode = rcpc_pkg::RCPC_SLUMBER;  // RULE2 RULE3
                        st_nxt.det  = 1'b1;                    // RULE5
                    end else begin
                        st_nxt.idle = st_r.idle + 1'b1;
                    end
                end
                rcpc_pkg::RCPC_SLUMBER: begin
                    if (sig_active) begin
                        st_nxt.mode = rcpc_pkg::RCPC_ACTIVE;  // RULE15
                        st_nxt.idle = '0;
                        st_nxt.det  = 1'b0;
                    end else if (st_r.det && det_done) begin
                        st_nxt.det = !det_load;  // Keep asking while unplugged
                        st_nxt.per = DET_PERIOD;
                        if (!det_load) begin
                            st_nxt.mode = rcpc_pkg::RCPC_UNPLUG;  // RULE6
                        end
                    end else if (!st_r.det) begin
                        if (st_r.per <= 20'h00001) begin
                            st_nxt.det = 1'b1;  // RULE7
                        end else begin
                            st_nxt.per = st_r.per - 1'b1;
                        end
                    end
                end
                rcpc_pkg::RCPC_UNPLUG: begin
                    st_nxt.det = 1'b1;  // RULE6
                    if (det_done && det_load) begin
                        st_nxt.mode = rcpc_pkg::RCPC_SLUMBER;  // RULE7
                        st_nxt.det  = 1'b0;
                        st_nxt.per  = DET_PERIOD;
                    end
                end
                default: begin
                    st_nxt.mode = rcpc_pkg::RCPC_POWER_DOWN_MODE;
                end
            endcase
        end
        // Terminations follow the mode being entered
        case (st_nxt.mode)
            rcpc_pkg::RCPC_ACTIVE: begin
                st_nxt.rx = rcpc_pkg::RX_TERM_50_VDD;  // RULE10
                st_nxt.tx = rcpc_pkg::TX_TERM_50_VDD;  // RULE10
                st_nxt.sd = 1'b1;
            end
            rcpc_pkg::RCPC_SLUMBER: begin
                st_nxt.rx = rcpc_pkg::RX_TERM_50_VDD;  // RULE10
                st_nxt.tx = rcpc_pkg::TX_TERM_40K_VD;  // RULE9
                st_nxt.sd = 1'b1;                      // RULE4
            end
            rcpc_pkg::RCPC_UNPLUG: begin
                st_nxt.rx = rcpc_pkg::RX_TERM_HIZ;     // RULE9
                st_nxt.tx = rcpc_pkg::TX_TERM_40K_VD;  // RULE9
                st_nxt.sd = 1'b1;
            end
            default: begin
                st_nxt.rx = rcpc_pkg::RX_TERM_67K_GN;  // RULE8
                st_nxt.tx = rcpc_pkg::TX_TERM_HIZ;     // RULE8
                st_nxt.sd = 1'b0;
            end
        endcase
    end

    // Register the state; clk_en freezes everything
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '{mode: rcpc_pkg::RCPC_POWER_DOWN_MODE, idle: '0, per: '0, det: 1'b0,
                      rx: rcpc_pkg::RX_TERM_67K_GN, tx: rcpc_pkg::TX_TERM_HIZ, sd: 1'b0};
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign mode      = st_r.mode;
    assign rx_term   = st_r.rx;
    assign tx_term   = st_r.tx;
    assign sd_enable = st_r.sd;
    assign det_req   = st_r.det;

endmodule

// ===== rtl/rcpc_top.sv
// Top: pin decode, AHB-Lite registers and four channel machines
//
// Functional notes
// RULE1: Pair enable low holds both channels powered down
// RULE2: Idle signal detector moves channel to slumber
// RULE3: Slumber decision made separately per channel
// RULE4: Signal detector stays on during slumber
// RULE5: Slumber runs far-end receiver detection
// RULE6: No load: unplug mode, keep detecting
// RULE7: Load found: back to slumber, detect every 6 ms
// RULE8: Power-down: weak input pull-down, output open
// RULE9: Unplug/slumber weak output pull-up; unplug input open
// RULE10: 50 ohm input in slumber/active; output active only
// RULE11: Equalization pin decodes to four codes, float default
// RULE12: Each channel has own EQ and gain selects
// RULE13: Flat gain pin decodes four codes, float default
// RULE14: Pair enable one bit, enabled by default
// RULE15: Activity in slumber returns channel to active
module rcpc_top #(
    parameter int unsigned NUM_CH     = 4,                         // Channels A..D
    parameter int unsigned DET_PERIOD = rcpc_pkg::DET_PERIOD_CYC   // Detection repeat in cycles
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    // Pair enable pins
    input  wire logic                pair_ab_enable,
    input  wire logic                pair_cd_enable,
    // Four-level selects as comparator thermometer codes
    input  wire logic [2:0]          eq_select_a,
    input  wire logic [2:0]          eq_select_b,
    input  wire logic [2:0]          eq_select_c,
    input  wire logic [2:0]          eq_select_d,
    input  wire logic [2:0]          flat_gain_sel_a,
    input  wire logic [2:0]          flat_gain_sel_b,
    input  wire logic [2:0]          flat_gain_sel_c,
    input  wire logic [2:0]          flat_gain_sel_d,
    // Analog detectors, bit 0 is channel A
    input  wire logic [NUM_CH-1:0]   sig_active,
    input  wire logic [NUM_CH-1:0]   det_done,
    input  wire logic [NUM_CH-1:0]   det_load,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic [1:0]               hresp,
    // Analog controls
    output logic [4*NUM_CH-1:0]      chan_mode,
    output logic [2*NUM_CH-1:0]      rx_term,
    output logic [2*NUM_CH-1:0]      tx_term,
    output logic [NUM_CH-1:0]        sd_enable,
    output logic [NUM_CH-1:0]        det_req,
    output logic [2*NUM_CH-1:0]      eq_code,
    output logic [2*NUM_CH-1:0]      gain_code
);

    // ==================================================================
    // Helpers
    // ==================================================================

    // Comparator code to setting; codes other than the four levels read as open
    function automatic logic [1:0] rcpc_lvl_decode(input logic [2:0] therm);
        logic [1:0] code;
        code = rcpc_pkg::SET_F;  // RULE11 RULE13
        case (therm)
            rcpc_pkg::LVL_THERM_L: code = rcpc_pkg::SET_L;
            rcpc_pkg::LVL_THERM_R: code = rcpc_pkg::SET_R;
            rcpc_pkg::LVL_THERM_F: code = rcpc_pkg::SET_F;
            rcpc_pkg::LVL_THERM_H: code = rcpc_pkg::SET_H;
            default:               code = rcpc_pkg::SET_F;
        endcase
        return code;
    endfunction

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        logic                          hready_o;  // Always ready, zero wait
        logic [31:0]                   rdata;     // Read data for data phase
        logic                          wr_pend;   // Write data phase pending
        logic [7:0]                    wr_addr;   // Address of pending write
        logic                          sw_ab;     // Software enable pair AB
        logic                          sw_cd;     // Software enable pair CD
        logic [rcpc_pkg::IDLE_W-1:0]   idle_qual; // Idle qualification cycles
        logic [2*NUM_CH-1:0]           eq;        // Decoded equalizer codes
        logic [2*NUM_CH-1:0]           gain;      // Decoded gain codes
    } rcpc_top_s;

    rcpc_top_s st_r;
    rcpc_top_s st_nxt;

    logic [3*NUM_CH-1:0]   eq_pins;     // Selects gathered per channel
    logic [3*NUM_CH-1:0]   gain_pins;
    logic [NUM_CH-1:0]     pair_en;     // Pair enable per channel
    logic [4*NUM_CH-1:0]   mode_vec;    // Channel modes
    logic                  addr_take;   // Address phase accepted
    logic [7:0]            rd_addr;     // Word address of read

    assign eq_pins   = {eq_select_d, eq_select_c, eq_select_b, eq_select_a};              // RULE12
    assign gain_pins = {flat_gain_sel_d, flat_gain_sel_c, flat_gain_sel_b, flat_gain_sel_a};  // RULE12

    // Pins one bit each; pulled-up pin and software reset both give 1
    always_comb begin
        pair_en[0] = pair_ab_enable & st_r.sw_ab;  // RULE14
        pair_en[1] = pair_ab_enable & st_r.sw_ab;  // RULE14
        pair_en[2] = pair_cd_enable & st_r.sw_cd;  // RULE14
        pair_en[3] = pair_cd_enable & st_r.sw_cd;  // RULE14
    end

    assign addr_take = hsel & hready & (htrans == rcpc_pkg::HTRANS_NONSEQ);
    assign rd_addr   = {haddr[7:2], 2'h0};

    // ==================================================================
    // Next state: pin decode and register file
    // ==================================================================
    always_comb begin
        st_nxt          = st_r;
        st_nxt.hready_o = 1'b1;

        // Re-decoded every cycle: pin changes show after the next enabled edge
        for (int i = 0; i < NUM_CH; i++) begin
            st_nxt.eq[2*i +: 2]   = rcpc_lvl_decode(eq_pins[3*i +: 3]);    // RULE11
            st_nxt.gain[2*i +: 2] = rcpc_lvl_decode(gain_pins[3*i +: 3]);  // RULE13
        end

        // Write data phase: hwdata is valid now
        if (st_r.wr_pend) begin
            case (st_r.wr_addr)
                rcpc_pkg::REG_CTRL: begin
                    st_nxt.sw_ab = hwdata[rcpc_pkg::CTRL_AB_BIT];  // RULE1
                    st_nxt.sw_cd = hwdata[rcpc_pkg::CTRL_CD_BIT];  // RULE1
                end
                rcpc_pkg::REG_IDLE_QUAL: begin
                    st_nxt.idle_qual = hwdata[rcpc_pkg::IDLE_W-1:0];  // RULE2
                end
                default: begin
                    // Read-only or unmapped: write dropped
                end
            endcase
        end
        st_nxt.wr_pend = 1'b0;

        // Address phase: writes wait for data, reads are answered next cycle
        if (addr_take) begin
            if (hwrite) begin
                st_nxt.wr_pend = 1'b1;
                st_nxt.wr_addr = rd_addr;
            end else begin
                // Read from next state so a write just before is seen
                case (rd_addr)
                    rcpc_pkg::REG_CTRL: begin
                        st_nxt.rdata = 32'h0;
                        st_nxt.rdata[rcpc_pkg::CTRL_AB_BIT] = st_nxt.sw_ab;
                        st_nxt.rdata[rcpc_pkg::CTRL_CD_BIT] = st_nxt.sw_cd;
                    end
                    rcpc_pkg::REG_IDLE_QUAL: begin
                        st_nxt.rdata = 32'(st_nxt.idle_qual);
                    end
                    rcpc_pkg::REG_STATUS: begin
                        st_nxt.rdata = 32'(mode_vec);
                    end
                    rcpc_pkg::REG_SETTINGS: begin
                        st_nxt.rdata = 32'({st_r.gain, st_r.eq});
                    end
                    default: begin
                        st_nxt.rdata = 32'h0;  // Unmapped reads as zero
                    end
                endcase
            end
        end
    end

    // Register the state; clk_en freezes everything
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '{hready_o: 1'b1, rdata: 32'h0, wr_pend: 1'b0, wr_addr: 8'h00,
                      sw_ab: 1'b1, sw_cd: 1'b1, idle_qual: rcpc_pkg::IDLE_QUAL_RST,
                      eq: {NUM_CH{rcpc_pkg::SET_F}}, gain: {NUM_CH{rcpc_pkg::SET_F}}};
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ==================================================================
    // Channels
    // ==================================================================
    // One machine per channel; none reads another's state
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        rcpc_pkg::rcpc_mode_e ch_mode;  // Mode of this channel

        rcpc_chan #(
            .DET_PERIOD (rcpc_pkg::PER_CNT_W'(DET_PERIOD))
        ) u_chan (
            .clk        (clk),
            .reset_n    (reset_n),
            .clk_en     (clk_en),
            .pair_en    (pair_en[c]),
            .sig_active (sig_active[c]),
            .det_done   (det_done[c]),
            .det_load   (det_load[c]),
            .idle_qual  (st_r.idle_qual),
            .mode       (ch_mode),
            .rx_term    (rx_term[2*c +: 2]),
            .tx_term    (tx_term[2*c +: 2]),
            .sd_enable  (sd_enable[c]),
            .det_req    (det_req[c])
        );  // RULE3

        assign mode_vec[4*c +: 4] = ch_mode;
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    assign chan_mode = mode_vec;
    assign hreadyout = st_r.hready_o;
    assign hrdata    = st_r.rdata;
    assign hresp     = rcpc_pkg::HRESP_OKAY;
    assign eq_code   = st_r.eq;
    assign gain_code = st_r.gain;

endmodule

// ===== testbench/rcpc_monitor.sv
// Checker: channel A mode, termination and decode relations at the top ports
module rcpc_monitor (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        pair_ab_enable,
    input wire logic [2:0]  eq_select_a,
    input wire logic [3:0]  sig_active,
    input wire logic [3:0]  det_done,
    input wire logic [3:0]  det_load,
    input wire logic [15:0] chan_mode,
    input wire logic [7:0]  rx_term,
    input wire logic [7:0]  tx_term,
    input wire logic [3:0]  sd_enable,
    input wire logic [3:0]  det_req,
    input wire logic [7:0]  eq_code
);
    // ==========================================================
    // Channel A only; software enable for pair AB is kept on
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic [3:0] ma = chan_mode[3:0];  // Mode of channel A
    wire logic       en = clk_en && pair_ab_enable;  // Edge that counts
    a_pair_off_pd: assert property (clk_en && !pair_ab_enable |=> ma == 4'h1)
        else $error("pair off, not powered down");
    a_pd_terms: assert property (ma == 4'h1 |-> rx_term[1:0] == 2'h1 && tx_term[1:0] == 2'h0)
        else $error("bad power-down terms");
    a_unplug_terms: assert property (ma == 4'h2 |-> rx_term[1:0] == 2'h0 && tx_term[1:0] == 2'h1)
        else $error("bad unplug terms");
    a_slumber_terms: assert property (ma == 4'h4 |-> rx_term[1:0] == 2'h2 && tx_term[1:0] == 2'h1 && sd_enable[0])
        else $error("bad slumber terms");
    a_active_terms: assert property (ma == 4'h8 |-> rx_term[1:0] == 2'h2 && tx_term[1:0] == 2'h2)
        else $error("bad active terms");
    a_idle_detect: assert property (ma == 4'h8 ##1 ma == 4'h4 |-> det_req[0])
        else $error("slumber without detection");
    a_busy_stays: assert property (en && ma == 4'h8 && sig_active[0] |=> ma == 4'h8)
        else $error("busy channel left active");
    a_wake_active: assert property (en && ma == 4'h4 && sig_active[0] && !det_done[0] |=> ma == 4'h8)
        else $error("no wake on activity");
    a_unplug_hold: assert property (en && ma == 4'h2 && !det_done[0] |=> ma == 4'h2 && det_req[0])
        else $error("unplug left without load");
    a_load_return: assert property (en && ma == 4'h2 && det_done[0] && det_load[0] |=> ma == 4'h4 && !det_req[0])
        else $error("no return to slumber");
    a_eq_high: assert property (clk_en && eq_select_a == 3'h7 |=> eq_code[1:0] == 2'h3)
        else $error("high level not decoded");
    c_unplug: cover property (ma == 4'h2);
    c_to_slumber: cover property (ma == 4'h8 ##1 ma == 4'h4);
    c_replug: cover property (ma == 4'h2 ##1 ma == 4'h4);
endmodule

// ===== testbench/rcpc_xcvr_model.sv
// Far-end transceiver model: answers detection requests after a set delay
module rcpc_xcvr_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] det_req,
    input  wire logic [3:0] plugged,   // Load present per channel
    input  wire logic [7:0] delay,     // Answer delay in cycles
    output logic      [3:0] det_done,
    output logic      [3:0] det_load
);
    logic [7:0] cnt [4];  // Per-channel delay counters
    // ==========================================================
    // Answer only while asked; result toggles when not valid
    // ==========================================================
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!reset_n || !det_req[i] || det_done[i]) begin
                cnt[i]      <= 8'h00;
                det_done[i] <= 1'b0;
                det_load[i] <= reset_n ? ~det_load[i] : 1'b0;
            end else if (cnt[i] >= delay) begin
                // Unplug keeps polling
                det_done[i] <= 1'b1;
                det_load[i] <= plugged[i];
            end else begin
                cnt[i]      <= cnt[i] + 8'h01;
                det_load[i] <= ~det_load[i];
            end
        end
    end
endmodule

// ===== testbench/redriver_channel_power_ctrl_test.sv
// Testbench: bus, pin decode, enables and power modes
module redriver_channel_power_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PER = 20;  // Short detection period
    logic        clk = 0, reset_n = 0, clk_en = 1, hsel = 0, hwrite = 0;
    logic        pair_ab_enable = 1, pair_cd_enable = 1, hreadyout;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0, hresp;
    logic [2:0]  eqs [4] = '{default: 3'h3}, fgs [4] = '{default: 3'h3};
    logic [3:0]  sig = 4'hf, plug = 4'hf, det_done, det_load, det_req, sd_enable;
    logic [7:0]  dly = 8'h03, rx_term, tx_term, eq_code, gain_code;
    logic [15:0] chan_mode;
    int          error_cnt = 0, check_count = 0, n;
    always #4 clk = ~clk;
    rcpc_top #(.DET_PERIOD(PER)) i_rcpc_top (.clk, .reset_n, .clk_en, .pair_ab_enable, .pair_cd_enable,
        .eq_select_a(eqs[0]), .eq_select_b(eqs[1]), .eq_select_c(eqs[2]), .eq_select_d(eqs[3]),
        .flat_gain_sel_a(fgs[0]), .flat_gain_sel_b(fgs[1]), .flat_gain_sel_c(fgs[2]), .flat_gain_sel_d(fgs[3]),
        .sig_active(sig), .det_done, .det_load, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .chan_mode, .rx_term, .tx_term, .sd_enable,
        .det_req, .eq_code, .gain_code);
    rcpc_xcvr_model i_rcpc_xcvr_model (.clk, .reset_n, .det_req, .plugged(plug), .delay(dly), .det_done, .det_load);
    // ==========================================================
    // Helpers
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Level code to setting
    function automatic logic [1:0] lvl(input logic [2:0] c);
        lvl = c == 3'h0 ? 2'h0 : c == 3'h1 ? 2'h1 : c == 3'h7 ? 2'h3 : 2'h2;
    endfunction
    // Mode to {rx, tx} terms
    function automatic logic [3:0] tm(input logic [3:0] m);
        tm = m == 4'h1 ? 4'h4 : m == 4'h2 ? 4'h1 : m == 4'h4 ? 4'h9 : 4'ha;
    endfunction
    // One whole-word transfer; entered just after a rising edge
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic wait_mode(input int ch, input logic [3:0] m);
        n = 0;
        while (chan_mode[4*ch+:4] !== m && n < 300) begin @(posedge clk); n++; end
        chk(chan_mode[4*ch+:4], m);
        chk({rx_term[2*ch+:2], tx_term[2*ch+:2]}, tm(m));
    endtask
    task automatic wait_req(input logic v);
        n = 0;
        while (det_req[0] !== v && n < 300) begin @(posedge clk); n++; end
    endtask
    task automatic test_done;
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        rd = $urandom(41);
        repeat (8) @(posedge clk);
        chk({chan_mode, eq_code, gain_code}, 32'h1111aaaa);
        chk({hresp, hreadyout, rx_term, tx_term}, 32'h15500);
        reset_n <= 1;
        @(posedge clk);
        bus(32'h0, 0, 0); chk(rd, 32'h3);
        bus(32'h8, 0, 0); chk(rd, 32'h8888);
        bus(32'hc, 0, 0); chk(rd, 32'haaaa);
        bus(32'h4, 0, 0); chk(rd, 32'h400);
        bus(32'h4, 1, 32'h4); bus(32'h4, 0, 0); chk(rd, 32'h4);
        bus(32'h10, 1, 32'hffff); bus(32'h10, 0, 0); chk(rd, 32'h0);
        bus(32'h0, 1, 32'h1); wait_mode(2, 4'h1); wait_mode(3, 4'h1);
        bus(32'h0, 1, 32'h3);
        repeat (24) begin
            for (int i = 0; i < 4; i++) begin eqs[i] <= 3'($urandom); fgs[i] <= 3'($urandom); end
            {pair_ab_enable, pair_cd_enable} <= 2'($urandom);
            repeat (3) @(posedge clk);
            for (int i = 0; i < 4; i++) begin
                chk(eq_code[2*i+:2], lvl(eqs[i]));
                chk(gain_code[2*i+:2], lvl(fgs[i]));
                chk(chan_mode[4*i+:4], (i < 2 ? pair_ab_enable : pair_cd_enable) ? 4'h8 : 4'h1);
            end
        end
        pair_ab_enable <= 1; pair_cd_enable <= 1; dly <= 8'd12; sig <= 4'he;
        wait_mode(0, 4'h4); chk({sd_enable, det_req, chan_mode[15:4]}, 32'hf1888);
        wait_req(0); wait_req(1);
        chk(n >= PER - 1 && n <= PER + 1, 1);
        plug <= 4'he; dly <= 8'd2; wait_mode(0, 4'h2);
        sig <= 4'hf; repeat (40) @(posedge clk);
        chk({chan_mode[3:0], det_req[0]}, 5'h5);
        sig <= 4'he; plug <= 4'hf; wait_mode(0, 4'h4);
        clk_en <= 0; sig <= 4'hf; repeat (6) @(posedge clk);
        chk(chan_mode[3:0], 4'h4);
        clk_en <= 1; wait_mode(0, 4'h8);
        test_done;
    end
    // Watchdog: run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule
bind rcpc_top rcpc_monitor i_rcpc_monitor (.clk, .reset_n, .clk_en, .pair_ab_enable, .eq_select_a, .sig_active,
    .det_done, .det_load, .chan_mode, .rx_term, .tx_term, .sd_enable, .det_req, .eq_code);
